// ===== dv/sei_enc_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Incremental encoder seen from the pins of the interface
// ------------------------------------------------------------------
// Lines are always driven, so they never float between moves.
// Every level is held for at least hold cycles, though the decoder
// counts a level from a single sample.
module sei_enc_model (
	input wire logic sys_clk,
	input wire logic fdMode,
	output logic pinA,
	output logic pinB,
	output logic pinZ
);
	logic [1:0] phase;

	initial begin
		pinA = 1'b0;
		pinB = 1'b0;
		pinZ = 1'b0;
		phase = 2'h0;
	end

	task automatic move(input int steps, input logic up, input int hold);
		repeat (steps) begin
			@(posedge sys_clk);
			if (fdMode) begin
				pinB <= up;
				pinA <= 1'b0;
				repeat (hold) @(posedge sys_clk);
				pinA <= 1'b1;
			end else begin
				phase = up ? phase + 2'h1 : phase - 2'h1;
				pinA <= phase[1] ^ phase[0];
				pinB <= phase[1];
			end
			repeat (hold - 1) @(posedge sys_clk);
		end
	endtask

	// Both channels change at once, which a real encoder only does on a glitch.
	task automatic jump();
		@(posedge sys_clk);
		phase = phase + 2'h2;
		pinA <= phase[1] ^ phase[0];
		pinB <= phase[1];
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic marker(input int hold);
		@(posedge sys_clk);
		pinZ <= 1'b1;
		repeat (hold) @(posedge sys_clk);
		pinZ <= 1'b0;
		repeat (hold) @(posedge sys_clk);
	endtask
endmodule // sei_enc_model

// ===== dv/tb_sei_encoder_two.sv
`timescale 1ns/1ps
module tb_sei_encoder_two;
	import sei_pkg::*;
	localparam int WIN = 200;
	localparam int LIMIT = 30000;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [7:0] wbAdr = 8'h00;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDat = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic enc2A, enc2B, enc2Z, enc1A, enc1B, enc1Z;
	logic fd2 = 1'b0;
	logic freezeIn = 1'b0;
	logic freezePinOut, freezePinOe, simOne, simTwo, encTermOn, freezeTermOn;
	logic prevOne = 1'b0;
	logic prevTwo = 1'b0;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int simEdges = 0;
	int oneEdges = 0;
	int n;
	int base;
	logic [31:0] expQ[$];

	always #10 sys_clk = ~sys_clk;

	sei_encoder_two #(.WINDOW_CYCLES(WIN)) uut (
		.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .enc2APin(enc2A), .enc2BPin(enc2B), .enc2ZPin(enc2Z),
		.enc1APin(enc1A), .enc1BPin(enc1B), .enc1ZPin(enc1Z), .freezePinIn(freezeIn),
		.freezePinOut(freezePinOut), .freezePinOe(freezePinOe),
		.simOutputChannelOne(simOne), .simOutputChannelTwo(simTwo),
		.encTermOn(encTermOn), .freezeTermOn(freezeTermOn)
	);
	sei_enc_model enc2 (.sys_clk(sys_clk), .fdMode(fd2), .pinA(enc2A), .pinB(enc2B),
		.pinZ(enc2Z));
	sei_enc_model enc1 (.sys_clk(sys_clk), .fdMode(1'b0), .pinA(enc1A), .pinB(enc1B),
		.pinZ(enc1Z));

	// ------------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------------
	task automatic end_of_test();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge sys_clk);
	endtask

	// The master never assumes a latency; only the cycle ceiling ends a wait.
	task automatic wbXfer(input logic [7:0] adr, input logic we, input logic [31:0] dat);
		@(posedge sys_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= 4'hf;
		wbDat <= dat;
		do begin
			@(posedge sys_clk);
		end while (wb_ack_o !== 1'b1);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wbXfer(adr, 1'b1, dat);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		expQ.push_back(exp);
		wbXfer(adr, 1'b0, 32'h0);
	endtask

	// ------------------------------------------------------------------
	// Watchers
	// ------------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (wb_ack_o === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
			check(wb_dat_o, expQ.pop_front());
		end
		if (simOne !== prevOne || simTwo !== prevTwo) simEdges++;
		if (simOne !== prevOne) oneEdges++;
		prevOne = simOne;
		prevTwo = simTwo;
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(28));
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		rd(ADDR_LINES, 32'h400);
		rd(ADDR_CONTROL, 32'h0);
		rd(ADDR_SCALE, 32'h0);
		rd(ADDR_POSITION, 32'h0);
		rd(ADDR_STATUS, 32'h0);
		rd(8'h20, 32'h0);
		check({29'h0, encTermOn, freezeTermOn, freezePinOe}, 32'h7);
		wr(ADDR_CONTROL, 32'h28);
		settle(3);
		check({29'h0, encTermOn, freezeTermOn, freezePinOe}, 32'h1);
		wr(ADDR_CONTROL, 32'h0);
		fork
			enc1.marker(8);
			begin
				settle(6);
				check({31'h0, freezePinOut}, 32'h1);
			end
		join
		check({31'h0, freezePinOut}, 32'h0);
		n = $urandom_range(40, 3);
		enc2.move(n, 1'b1, 4);
		// A position job can wait behind a stale job and a speed job.
		settle(150);
		rd(ADDR_POSITION, 32'(4 * n));
		enc2.move(n + 2, 1'b0, 4);
		settle(150);
		rd(ADDR_POSITION, 32'h3ff8);
		wr(ADDR_POSITION, 32'h1234);
		rd(ADDR_POSITION, 32'h3ff8);
		wr(ADDR_LINES, 32'h7fff);
		rd(ADDR_LINES, 32'h4000);
		wr(ADDR_LINES, 32'h400);
		enc2.marker(6);
		settle(150);
		rd(ADDR_POSITION, 32'h0);
		enc2.move(3, 1'b1, 4);
		enc2.jump();
		settle(150);
		rd(ADDR_POSITION, 32'hc);
		wr(ADDR_CONTROL, 32'h1);
		fd2 <= 1'b1;
		enc2.marker(6);
		enc2.move(10, 1'b1, 4);
		settle(150);
		rd(ADDR_POSITION, 32'ha0);
		enc2.move(4, 1'b0, 4);
		settle(150);
		rd(ADDR_POSITION, 32'h60);
		enc1.move(6, 1'b1, 4);
		wr(ADDR_CONTROL, 32'h11);
		settle(3);
		check({31'h0, freezePinOe}, 32'h0);
		freezeIn <= 1'b1;
		settle(6);
		freezeIn <= 1'b0;
		rd(ADDR_FRZ_POS2, 32'h60);
		rd(ADDR_FRZ_POS1, 32'h6);
		rd(ADDR_STATUS, 32'h3);
		wr(ADDR_STATUS, 32'h2);
		rd(ADDR_STATUS, 32'h1);
		// Whole multiples of 2 to the power of the scale (16 here) make the edge count independent of the start value.
		wr(ADDR_SCALE, 32'h4);
		wr(ADDR_CONTROL, 32'h13);
		settle(10);
		base = simEdges;
		enc1.move(64, 1'b1, 4);
		enc2.move(32, 1'b1, 4);
		settle(10);
		check(32'(simEdges - base), 32'h4);
		wr(ADDR_CONTROL, 32'h17);
		settle(10);
		base = oneEdges;
		enc1.move(64, 1'b1, 4);
		settle(10);
		check(32'(oneEdges - base), 32'h4);
		check({31'h0, simTwo}, 32'h1);
		enc1.move(16, 1'b0, 4);
		settle(10);
		check({31'h0, simTwo}, 32'h0);
		wr(ADDR_CONTROL, 32'h15);
		settle(10);
		base = oneEdges;
		enc2.move(32, 1'b1, 4);
		settle(10);
		check(32'(oneEdges - base), 32'h2);
		// One edge every 8 cycles gives exactly 25 edges in each full window.
		wr(ADDR_LINES, 32'h3e8);
		wr(ADDR_CONTROL, 32'h1);
		fork
			enc2.move(100, 1'b1, 4);
			begin
				settle(700);
				rd(ADDR_SPEED, 32'h96);
			end
		join
		wr(ADDR_LINES, 32'h1);
		wr(ADDR_CONTROL, 32'h1);
		fork
			enc2.move(100, 1'b1, 4);
			begin
				settle(600);
				rd(ADDR_SPEED, 32'h7530);
			end
		join
		fork
			enc2.move(100, 1'b0, 4);
			begin
				settle(600);
				rd(ADDR_SPEED, 32'hffff8ad0);
			end
		join
		settle(5);
		end_of_test();
	end
endmodule // tb_sei_encoder_two

// ===== rtl/sei_divider.sv
`timescale 1ns/1ps
module sei_divider
	import sei_pkg::*;
#(
	parameter int DW = 40,
	parameter int VW = 17
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [DW-1:0] dividend,
	input wire logic [VW-1:0] divisor,
	output logic done,
	output logic [DW-1:0] quotient
);
	localparam int CW = $clog2(DW + 1);

	typedef struct packed {
		logic [DW-1:0] quo;
		logic [VW-1:0] rem;
		logic [VW-1:0] div;
		logic [CW-1:0] cnt;
		logic busy;
		logic done;
	} sei_div_s;

	sei_div_s r_q;
	sei_div_s r_d;

	// ------------------------------------------------------------------
	// Restoring division, one quotient bit per clock
	// ------------------------------------------------------------------
	always_comb begin
		logic [VW:0] shifted;
		logic bitOut;
		shifted = {r_q.rem, r_q.quo[DW-1]};
		bitOut = 1'b0;
		r_d = r_q;
		r_d.done = 1'b0;
		if (start) begin
			// The divisor is captured so that a register write cannot upset a running job.
			r_d.quo = dividend;
			r_d.rem = '0;
			r_d.div = divisor;
			r_d.cnt = CW'(DW);
			r_d.busy = 1'b1;
		end else if (r_q.busy) begin
			if (shifted >= {1'b0, r_q.div}) begin
				bitOut = 1'b1;
				r_d.rem = VW'(shifted - {1'b0, r_q.div});
			end else begin
				r_d.rem = VW'(shifted);
			end
			r_d.quo = {r_q.quo[DW-2:0], bitOut};
			r_d.cnt = r_q.cnt - 1'b1;
			if (r_q.cnt == CW'(1)) begin
				r_d.busy = 1'b0;
				r_d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign done = r_q.done;
	assign quotient = r_q.quo;

endmodule // sei_divider

// ===== rtl/sei_encoder_two.sv
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module sei_encoder_two
	import sei_pkg::*;
#(
	parameter int WINDOW_CYCLES = SPEED_WINDOW_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic enc2APin,
	input wire logic enc2BPin,
	input wire logic enc2ZPin,
	input wire logic enc1APin,
	input wire logic enc1BPin,
	input wire logic enc1ZPin,
	input wire logic freezePinIn,
	output logic freezePinOut,
	output logic freezePinOe,
	output logic simOutputChannelOne,
	output logic simOutputChannelTwo,
	output logic encTermOn,
	output logic freezeTermOn
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {JOB_IDLE, JOB_POS, JOB_SPD} sei_job_e;

	typedef struct packed {
		logic [2:0] enc2S1;
		logic [2:0] enc2S2;
		logic [2:0] enc2Prev;
		logic [2:0] enc1S1;
		logic [2:0] enc1S2;
		logic [2:0] enc1Prev;
		logic frzS1;
		logic frzS2;
		logic frzPrev;
		logic [14:0] lines;
		logic [5:0] ctrl;
		logic [3:0] scale;
		logic [16:0] count;
		logic markerSeen;
		logic [13:0] position;
		logic signed [15:0] speed;
		logic [13:0] frzPos2;
		logic [15:0] frzPos1;
		logic [15:0] enc1Count;
		logic frozen;
		logic [23:0] winCnt;
		logic signed [23:0] winEdges;
		logic signed [23:0] speedEdges;
		logic speedPending;
		logic speedNeg;
		sei_job_e job;
		logic divStart;
		logic [39:0] divDividend;
		logic [16:0] divDivisor;
		logic [19:0] srcCount;
		logic outDir;
		logic simOne;
		logic simTwo;
		logic markerOut;
		logic frzOe;
		logic encTermOn;
		logic frzTermOn;
		logic ack;
		logic [31:0] rdData;
	} sei_state_s;

	sei_state_s r_q;
	sei_state_s r_d;

	logic divDone;
	logic [39:0] divQuo;
	logic fdMode;
	logic [16:0] cprNow;
	sei_step_t enc2Step;
	sei_step_t enc1Step;
	sei_step_t srcStep;
	logic markerRise;
	logic freezeRise;
	logic busReq;
	logic [19:0] scaled;

	// Counts per revolution: four edges per line in quadrature, one in F and D.
	function automatic logic [16:0] cprOf(input logic [14:0] lines, input logic fd);
		cprOf = fd ? {2'h0, lines} : {lines, 2'h0};
	endfunction

	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			laneMerge[i*8 +: 8] = sel[i] ? wdat[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	function automatic logic signed [23:0] stepDelta(input sei_step_t step);
		stepDelta = !step[1] ? 24'sh000000 : (step[0] ? -24'sh000001 : 24'sh000001);
	endfunction

	// ------------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------------
	assign fdMode = r_q.ctrl[CTRL_INPUT_TYPE];
	assign cprNow = cprOf(r_q.lines, fdMode);
	// In F and D mode a rising frequency edge counts, the direction line gives the sign.
	assign enc2Step = fdMode ? ((r_q.enc2S2[2] & ~r_q.enc2Prev[2]) ?
		(r_q.enc2S2[1] ? STEP_UP : STEP_DOWN) : STEP_NONE) :
		seiQuadStep(r_q.enc2Prev[2:1], r_q.enc2S2[2:1]);
	assign enc1Step = seiQuadStep(r_q.enc1Prev[2:1], r_q.enc1S2[2:1]);
	assign srcStep = r_q.ctrl[CTRL_OUT_SOURCE] ? enc1Step : enc2Step;
	assign markerRise = r_q.enc2S2[0] & ~r_q.enc2Prev[0];
	assign freezeRise = r_q.frzS2 & ~r_q.frzPrev & r_q.ctrl[CTRL_FRZ_ENABLE];
	assign busReq = wb_cyc_i & wb_stb_i & ~r_q.ack;
	assign scaled = r_q.srcCount >> r_q.scale;

	sei_divider #(
		.DW(40),
		.VW(17)
	) u_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(r_q.divStart),
		.dividend(r_q.divDividend),
		.divisor(r_q.divDivisor),
		.done(divDone),
		.quotient(divQuo)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [31:0] merged;
		logic [23:0] absEdges;
		logic [39:0] mag;
		merged = '0;
		absEdges = '0;
		mag = '0;
		r_d = r_q;
		r_d.divStart = 1'b0;

		// Pins pass two flip-flops before anything reads them.
		r_d.enc2S1 = {enc2APin, enc2BPin, enc2ZPin};
		r_d.enc2S2 = r_q.enc2S1;
		r_d.enc2Prev = r_q.enc2S2;
		r_d.enc1S1 = {enc1APin, enc1BPin, enc1ZPin};
		r_d.enc1S2 = r_q.enc1S1;
		r_d.enc1Prev = r_q.enc1S2;
		r_d.frzS1 = freezePinIn;
		r_d.frzS2 = r_q.frzS1;
		r_d.frzPrev = r_q.frzS2;

		// Revolution count, kept below the counts per revolution.
		if (r_q.count >= cprNow) begin
			r_d.count = '0;
		end else if (enc2Step == STEP_UP) begin
			r_d.count = (r_q.count == cprNow - 17'h1) ? 17'h0 : r_q.count + 17'h1;
		end else if (enc2Step == STEP_DOWN) begin
			r_d.count = (r_q.count == 17'h0) ? cprNow - 17'h1 : r_q.count - 17'h1;
		end
		if (markerRise) begin
			r_d.count = '0;
			r_d.markerSeen = 1'b1;
		end

		// Main encoder count, for the freeze latch.
		if (enc1Step[1]) begin
			r_d.enc1Count = enc1Step[0] ? r_q.enc1Count - 16'h1 : r_q.enc1Count + 16'h1;
		end

		// One shared divider serves position and speed in turn.
		unique case (r_q.job)
			JOB_IDLE: begin
				if (r_q.speedPending) begin
					r_d.speedPending = 1'b0;
					if (cprNow == 17'h0) begin
						r_d.speed = '0;
					end else begin
						absEdges = r_q.speedEdges[23] ? 24'(-r_q.speedEdges) : r_q.speedEdges;
						r_d.divDividend = 40'(absEdges) * 40'(RPM_FACTOR);
						r_d.divDivisor = cprNow;
						r_d.speedNeg = r_q.speedEdges[23];
						r_d.divStart = 1'b1;
						r_d.job = JOB_SPD;
					end
				end else if (cprNow == 17'h0) begin
					r_d.position = '0;
				end else begin
					r_d.divDividend = 40'({r_q.count, 14'h0});
					r_d.divDivisor = cprNow;
					r_d.divStart = 1'b1;
					r_d.job = JOB_POS;
				end
			end
			JOB_POS: begin
				if (divDone) begin
					r_d.position = 14'(divQuo);
					r_d.job = JOB_IDLE;
				end
			end
			JOB_SPD: begin
				if (divDone) begin
					mag = (divQuo > RPM_LIMIT) ? RPM_LIMIT : divQuo;
					r_d.speed = r_q.speedNeg ? -16'(mag) : 16'(mag);
					r_d.job = JOB_IDLE;
				end
			end
		endcase

		// Speed window; a new result overrides a clear by the sequencer above.
		if (r_q.winCnt == 24'(WINDOW_CYCLES - 1)) begin
			r_d.winCnt = '0;
			r_d.speedEdges = r_q.winEdges;
			r_d.winEdges = stepDelta(enc2Step);
			r_d.speedPending = 1'b1;
		end else begin
			r_d.winCnt = r_q.winCnt + 24'h1;
			r_d.winEdges = r_q.winEdges + stepDelta(enc2Step);
		end

		// Simulated output.
		if (srcStep[1]) begin
			r_d.srcCount = srcStep[0] ? r_q.srcCount - 20'h1 : r_q.srcCount + 20'h1;
			r_d.outDir = ~srcStep[0];
		end
		if (r_q.ctrl[CTRL_OUT_MODE]) begin
			r_d.simOne = scaled[0];
			r_d.simTwo = r_q.outDir;
		end else begin
			r_d.simOne = scaled[1];
			r_d.simTwo = scaled[1] ^ scaled[0];
		end

		// Pins and termination controls.
		r_d.markerOut = r_q.enc1S2[0];
		r_d.frzOe = ~r_q.ctrl[CTRL_FRZ_ENABLE];
		r_d.encTermOn = ~r_q.ctrl[CTRL_ENC_TERM_DIS];
		r_d.frzTermOn = ~r_q.ctrl[CTRL_FRZ_TERM_DIS];

		// Register bus, answered one cycle after the request.
		r_d.ack = busReq;
		if (busReq && wb_we_i) begin
			unique case (wb_adr_i)
				ADDR_LINES: begin
					merged = laneMerge({17'h0, r_q.lines}, wb_dat_i, wb_sel_i);
					r_d.lines = (merged[15:0] > LINES_MAX) ? LINES_MAX[14:0] : merged[14:0];
				end
				ADDR_CONTROL: begin
					merged = laneMerge({26'h0, r_q.ctrl}, wb_dat_i, wb_sel_i);
					r_d.ctrl = merged[5:0];
				end
				ADDR_SCALE: begin
					merged = laneMerge({28'h0, r_q.scale}, wb_dat_i, wb_sel_i);
					r_d.scale = merged[3:0];
				end
				ADDR_STATUS: begin
					if (wb_sel_i[0] && wb_dat_i[STAT_FROZEN]) begin
						r_d.frozen = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (busReq) begin
			unique case (wb_adr_i)
				ADDR_POSITION: r_d.rdData = {18'h0, r_q.position};
				ADDR_LINES: r_d.rdData = {17'h0, r_q.lines};
				ADDR_CONTROL: r_d.rdData = {26'h0, r_q.ctrl};
				ADDR_SCALE: r_d.rdData = {28'h0, r_q.scale};
				ADDR_SPEED: r_d.rdData = 32'(r_q.speed);
				ADDR_FRZ_POS2: r_d.rdData = {18'h0, r_q.frzPos2};
				ADDR_FRZ_POS1: r_d.rdData = {16'h0, r_q.frzPos1};
				ADDR_STATUS: r_d.rdData = {30'h0, r_q.frozen, r_q.markerSeen};
				default: r_d.rdData = '0;
			endcase
		end

		// Freeze latch; setting wins over a clear in the same cycle.
		if (freezeRise) begin
			r_d.frzPos2 = r_q.position;
			r_d.frzPos1 = r_q.enc1Count;
			r_d.frozen = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r_q <= '0;
			r_q.lines <= LINES_RESET;
			r_q.ctrl <= CTRL_RESET;
			r_q.scale <= SCALE_RESET;
			r_q.encTermOn <= 1'b1;
			r_q.frzTermOn <= 1'b1;
			r_q.frzOe <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	assign wb_dat_o = r_q.rdData;
	assign wb_ack_o = r_q.ack;
	assign freezePinOut = r_q.markerOut;
	assign freezePinOe = r_q.frzOe;
	assign simOutputChannelOne = r_q.simOne;
	assign simOutputChannelTwo = r_q.simTwo;
	assign encTermOn = r_q.encTermOn;
	assign freezeTermOn = r_q.frzTermOn;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_bus_ack_pulse: assert property (r_q.ack |=> !r_q.ack)
		else $error("ack held longer than one cycle");
	a_bus_ack_next: assert property (busReq |=> r_q.ack)
		else $error("request not answered in one cycle");
	a_count_range: assert property ($stable(cprNow) && cprNow != 17'h0 |-> r_q.count < cprNow)
		else $error("count outside one revolution");
	a_marker_rezero: assert property (markerRise |=> r_q.count == 17'h0 && r_q.markerSeen)
		else $error("marker did not re-zero the count");
	a_pos_divisor: assert property (r_q.divStart |-> r_q.divDivisor == $past(cprNow))
		else $error("divisor not taken from lines setting");
	a_quad_double: assert property (!fdMode && (r_q.enc2Prev[2:1] ^ r_q.enc2S2[2:1]) == 2'h3
		|-> enc2Step == STEP_NONE)
		else $error("double transition was counted");
	a_fd_direction: assert property (fdMode && r_q.enc2S2[2] && !r_q.enc2Prev[2]
		|-> enc2Step == (r_q.enc2S2[1] ? STEP_UP : STEP_DOWN))
		else $error("frequency edge decoded wrongly");
	a_src_main: assert property (r_q.ctrl[CTRL_OUT_SOURCE] && enc1Step == STEP_UP
		|=> r_q.srcCount == $past(r_q.srcCount) + 20'h1)
		else $error("main encoder step not passed to output");
	a_sim_quad: assert property (!r_q.ctrl[CTRL_OUT_MODE]
		|=> r_q.simOne == $past(scaled[1]) && r_q.simTwo == $past(scaled[1] ^ scaled[0]))
		else $error("quadrature output not from scaled count");
	a_sim_fd: assert property (r_q.ctrl[CTRL_OUT_MODE] |=> r_q.simTwo == $past(r_q.outDir))
		else $error("direction output wrong");
	a_enc_term: assert property (##1 encTermOn == !$past(r_q.ctrl[CTRL_ENC_TERM_DIS]))
		else $error("encoder termination control wrong");
	a_frz_term: assert property (##1 freezeTermOn == !$past(r_q.ctrl[CTRL_FRZ_TERM_DIS]))
		else $error("freeze termination control wrong");
	a_marker_route: assert property (!r_q.ctrl[CTRL_FRZ_ENABLE]
		|=> freezePinOe && freezePinOut == $past(r_q.enc1S2[0]))
		else $error("main marker not routed to freeze pins");
	a_freeze_latch: assert property (freezeRise
		|=> r_q.frzPos2 == $past(r_q.position) && r_q.frzPos1 == $past(r_q.enc1Count))
		else $error("freeze did not latch both positions");
	a_speed_bound: assert property (r_q.speed <= 16'sh7530 && r_q.speed >= -16'sh7530)
		else $error("speed beyond limit");

	c_marker: cover property (markerRise);
	c_freeze: cover property (freezeRise);
	c_speed_done: cover property (r_q.job == JOB_SPD && divDone);
	c_wrap_down: cover property (enc2Step == STEP_DOWN && r_q.count == 17'h0);

endmodule // sei_encoder_two

// ===== shared/sei_pkg.sv
package sei_pkg;

	// ------------------------------------------------------------------
	// Register map, byte addresses on the bus
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_POSITION = 8'h00;
	localparam logic [7:0] ADDR_LINES = 8'h04;
	localparam logic [7:0] ADDR_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_SCALE = 8'h0c;
	localparam logic [7:0] ADDR_SPEED = 8'h10;
	localparam logic [7:0] ADDR_FRZ_POS2 = 8'h14;
	localparam logic [7:0] ADDR_FRZ_POS1 = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;

	// ------------------------------------------------------------------
	// Control and status fields
	// ------------------------------------------------------------------
	localparam int CTRL_INPUT_TYPE = 0;
	localparam int CTRL_OUT_SOURCE = 1;
	localparam int CTRL_OUT_MODE = 2;
	localparam int CTRL_ENC_TERM_DIS = 3;
	localparam int CTRL_FRZ_ENABLE = 4;
	localparam int CTRL_FRZ_TERM_DIS = 5;
	localparam int STAT_MARKER_SEEN = 0;
	localparam int STAT_FROZEN = 1;

	// ------------------------------------------------------------------
	// Reset values and limits
	// ------------------------------------------------------------------
	localparam logic [14:0] LINES_RESET = 15'h0400;
	localparam logic [15:0] LINES_MAX = 16'h4000;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [3:0] SCALE_RESET = 4'h0;
	localparam logic [39:0] RPM_LIMIT = 40'h0000007530;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int SPEED_WINDOW_MS = 10;
	localparam int SPEED_WINDOW_CYCLES = CLK_HZ / 1000 * SPEED_WINDOW_MS;
	localparam int RPM_FACTOR = 60 * 1000 / SPEED_WINDOW_MS;

	// ------------------------------------------------------------------
	// Step codes and decoding
	// ------------------------------------------------------------------
	localparam logic [1:0] STEP_NONE = 2'h0;
	localparam logic [1:0] STEP_UP = 2'h2;
	localparam logic [1:0] STEP_DOWN = 2'h3;

	typedef logic [1:0] sei_step_t;

	// A leading B counts up; a change on both channels at once is dropped.
	function automatic sei_step_t seiQuadStep(input logic [1:0] prevAb, input logic [1:0] curAb);
		unique case ({prevAb, curAb})
			4'h2, 4'hb, 4'hd, 4'h4: seiQuadStep = STEP_UP;
			4'h1, 4'h7, 4'he, 4'h8: seiQuadStep = STEP_DOWN;
			default: seiQuadStep = STEP_NONE;
		endcase
	endfunction

endpackage
